/* File: src/plao_port.sv */
// Port output latch, pin read-back and alternate output combining
module plao_port
  import plao_pkg::*;
(
  // Clock and control
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              ce,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [DATA_W-1:0] avs_readdata,
  output logic                   avs_waitrequest,
  // Peripheral alternate outputs
  input  wire logic [PORT_W-1:0] serial_unit_out,
  input  wire logic [PORT_W-1:0] timer_unit_out,
  input  wire logic              clock_buzzer_output,
  // Pins
  input  wire logic [PORT_W-1:0] pin_in,
  output logic      [PORT_W-1:0] pin_out,
  output logic      [PORT_W-1:0] pin_oe,
  output logic      [PORT_W-1:0] analog_select_ctrl
);

  // ==========================================================
  // Registers
  logic [PORT_W-1:0] port_output_latch_r;
  logic [PORT_W-1:0] port_mode_r;
  logic [PORT_W-1:0] analog_sel_r;
  logic [PORT_W-1:0] open_drain_select_r;
  logic [PORT_W-1:0] pin_redirect_reg_r;
  logic [PORT_W-1:0] serial_out_enable_reg_r;
  logic [PORT_W-1:0] serial_out_level_reg_r;
  logic [PORT_W-1:0] channel_enable_status_reg_r;
  logic [PORT_W-1:0] timer_out_enable_reg_r;
  logic [PORT_W-1:0] timer_out_level_reg_r;
  logic [PORT_W-1:0] clock_out_select_reg_r;
  logic [DATA_W-1:0] readdata_r;
  logic [PORT_W-1:0] pin_out_r;
  logic [PORT_W-1:0] pin_oe_r;
  plao_bus_type      bus_r;
  logic              waitreq_r;

  // ==========================================================
  // Pin synchroniser
  plao_sync_if sif ();
  assign sif.pin_raw = pin_in;

  plao_pin_sync u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .sif     (sif)
  );

  // ==========================================================
  // Bus decode
  // Every access taken with ce high gets exactly one wait cycle: waitrequest is a flop,
  // so the answer cannot come in the request cycle itself.
  wire               req       = avs_read | avs_write;
  wire               answer    = (bus_r == BUS_ANSWER);
  wire               wr_en     = avs_write & answer & avs_byteenable[0];
  wire [ADDR_W-1:0]  wofs      = {avs_address[ADDR_W-1:2], 2'b00};
  wire [PORT_W-1:0]  wdat      = avs_writedata[PORT_W-1:0];
  wire               wr_latch  = wr_en & (wofs == OFS_PORT_LATCH);
  wire               wr_mode   = wr_en & (wofs == OFS_PORT_MODE);
  wire               wr_anl    = wr_en & (wofs == OFS_ANALOG_SEL);
  wire               wr_od     = wr_en & (wofs == OFS_OPEN_DRAIN);
  wire               wr_redir  = wr_en & (wofs == OFS_PIN_REDIRECT);
  wire               wr_soe    = wr_en & (wofs == OFS_SER_OUT_EN);
  wire               wr_sol    = wr_en & (wofs == OFS_SER_OUT_LVL);
  wire               wr_chen   = wr_en & (wofs == OFS_CHAN_EN);
  wire               wr_toe    = wr_en & (wofs == OFS_TMR_OUT_EN);
  wire               wr_tol    = wr_en & (wofs == OFS_TMR_OUT_LVL);
  wire               wr_cks    = wr_en & (wofs == OFS_CLK_OUT_SEL);

  // ==========================================================
  // Port read-back
  // Analog pins read as zero on the digital path
  wire [PORT_W-1:0]  pin_digital = sif.pin_level & ~analog_sel_r;
  // Output bits read the latch, input bits the pin; this read is also the
  // operand of a read-modify-write, so the write back lands in the latch.
  wire [PORT_W-1:0]  port_read   = (port_mode_r & pin_digital)
                                 | (~port_mode_r & port_output_latch_r);

  logic [PORT_W-1:0] rd_sel;
  always_comb begin
    unique case (wofs)
      OFS_PORT_LATCH:   rd_sel = port_read;
      OFS_PORT_MODE:    rd_sel = port_mode_r;
      OFS_ANALOG_SEL:   rd_sel = analog_sel_r;
      OFS_OPEN_DRAIN:   rd_sel = open_drain_select_r & HAS_OD_MASK;
      OFS_PIN_REDIRECT: rd_sel = pin_redirect_reg_r;
      OFS_SER_OUT_EN:   rd_sel = serial_out_enable_reg_r;
      OFS_SER_OUT_LVL:  rd_sel = serial_out_level_reg_r;
      OFS_CHAN_EN:      rd_sel = channel_enable_status_reg_r;
      OFS_TMR_OUT_EN:   rd_sel = timer_out_enable_reg_r;
      OFS_TMR_OUT_LVL:  rd_sel = timer_out_level_reg_r;
      OFS_CLK_OUT_SEL:  rd_sel = clock_out_select_reg_r;
      OFS_PIN_LEVEL:    rd_sel = sif.pin_level;
      default:          rd_sel = '0;
    endcase
  end

  wire [DATA_W-1:0]  readdata_nxt = {{(DATA_W-PORT_W){1'b0}}, rd_sel};

  // ==========================================================
  // Alternate output terms
  // Serial term: live data while channel and output are enabled,
  // otherwise the parked level bit, which resets high.
  wire [PORT_W-1:0]  ser_live  = serial_out_enable_reg_r & channel_enable_status_reg_r;
  wire [PORT_W-1:0]  ser_term  = (ser_live & serial_unit_out)
                               | (~ser_live & serial_out_level_reg_r);
  wire [PORT_W-1:0]  tmr_term  = (timer_out_enable_reg_r & timer_unit_out)
                               | (~timer_out_enable_reg_r & timer_out_level_reg_r);
  wire               buz_on    = clock_out_select_reg_r[CLK_OUT_EN_BIT] & clock_buzzer_output;
  wire               buz_redir = pin_redirect_reg_r[REDIR_BUZ_BIT];
  wire [PORT_W-1:0]  buz_vec   = buz_on ? (buz_redir ? PORT_W'(1) << BUZ_PIN_REDIRECT
                                                     : PORT_W'(1) << BUZ_PIN_NORMAL)
                                        : '0;

  // Absent sources fall to their neutral levels
  wire [PORT_W-1:0]  and_in    = ser_term | ~HAS_SER_MASK;
  wire [PORT_W-1:0]  or_in     = (tmr_term | buz_vec) & HAS_NS_MASK;
  wire [PORT_W-1:0]  od_sel    = open_drain_select_r & HAS_OD_MASK;
  wire [PORT_W-1:0]  combined  = (and_in & port_output_latch_r) | or_in;

  // Driver only in digital output mode; open-drain bits drive low only
  wire [PORT_W-1:0]  drive_en  = ~port_mode_r & ~analog_sel_r;
  wire [PORT_W-1:0]  oe_nxt    = drive_en & (~od_sel | ~combined);

  // ==========================================================
  // Bus handshake and read data
  // Waitrequest has a flop of its own, so the bus sees it straight
  // from a register and never through the phase decode.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus_r <= BUS_WAIT;
    end else if (ce) begin
      if (answer) begin
        bus_r <= BUS_WAIT;
      end else if (req) begin
        bus_r <= BUS_ANSWER;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      waitreq_r <= 1'b1;
    end else if (ce) begin
      if (answer) begin
        waitreq_r <= 1'b1;
      end else if (req) begin
        waitreq_r <= 1'b0;
      end
    end
  end

  // Captured as the access is taken; stands until the next access
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      readdata_r <= '0;
    end else if (ce && req && !answer) begin
      readdata_r <= readdata_nxt;
    end
  end

  // ==========================================================
  // Port latch
  // Writes land in the latch whatever the direction; nothing else moves it.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      port_output_latch_r <= RST_PORT_LATCH;
    end else if (ce && wr_latch) begin
      port_output_latch_r <= wdat;
    end
  end

  // ==========================================================
  // Control registers
  // One short block per register; each loads only on its own decoded write.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      port_mode_r <= RST_PORT_MODE;
    end else if (ce && wr_mode) begin
      port_mode_r <= wdat;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      analog_sel_r <= RST_ANALOG_SEL;
    end else if (ce && wr_anl) begin
      analog_sel_r <= wdat;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      open_drain_select_r <= RST_OPEN_DRAIN;
    end else if (ce && wr_od) begin
      open_drain_select_r <= wdat;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_redirect_reg_r <= RST_PIN_REDIRECT;
    end else if (ce && wr_redir) begin
      pin_redirect_reg_r <= wdat;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      serial_out_enable_reg_r <= RST_SER_OUT_EN;
    end else if (ce && wr_soe) begin
      serial_out_enable_reg_r <= wdat;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      serial_out_level_reg_r <= RST_SER_OUT_LVL;
    end else if (ce && wr_sol) begin
      serial_out_level_reg_r <= wdat;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      channel_enable_status_reg_r <= RST_CHAN_EN;
    end else if (ce && wr_chen) begin
      channel_enable_status_reg_r <= wdat;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timer_out_enable_reg_r <= RST_TMR_OUT_EN;
    end else if (ce && wr_toe) begin
      timer_out_enable_reg_r <= wdat;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timer_out_level_reg_r <= RST_TMR_OUT_LVL;
    end else if (ce && wr_tol) begin
      timer_out_level_reg_r <= wdat;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clock_out_select_reg_r <= RST_CLK_OUT_SEL;
    end else if (ce && wr_cks) begin
      clock_out_select_reg_r <= wdat;
    end
  end

  // ==========================================================
  // Pin drivers
  // Registered so every output is a flop; pins follow settings one cycle late.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_out_r <= '0;
      pin_oe_r  <= '0;
    end else if (ce) begin
      pin_out_r <= combined;
      pin_oe_r  <= oe_nxt;
    end
  end

  assign avs_readdata       = readdata_r;
  assign avs_waitrequest    = waitreq_r;
  assign pin_out            = pin_out_r;
  assign pin_oe             = pin_oe_r;
  assign analog_select_ctrl = analog_sel_r;

endmodule // plao_port

/* File: src/plao_pkg.sv */
// Constants for the port latch and alternate-output block
package plao_pkg;

  // ==========================================================
  // Widths
  localparam int unsigned PORT_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // ==========================================================
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_PORT_LATCH   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PORT_MODE    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_ANALOG_SEL   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_OPEN_DRAIN   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_PIN_REDIRECT = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_SER_OUT_EN   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_SER_OUT_LVL  = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_CHAN_EN      = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_TMR_OUT_EN   = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_TMR_OUT_LVL  = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_CLK_OUT_SEL  = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_PIN_LEVEL    = 8'h2C;

  // ==========================================================
  // Reset values
  localparam logic [PORT_W-1:0] RST_PORT_LATCH   = 8'h00;
  localparam logic [PORT_W-1:0] RST_PORT_MODE    = 8'hFF;
  localparam logic [PORT_W-1:0] RST_ANALOG_SEL   = 8'hFF;
  localparam logic [PORT_W-1:0] RST_OPEN_DRAIN   = 8'h00;
  localparam logic [PORT_W-1:0] RST_PIN_REDIRECT = 8'h00;
  localparam logic [PORT_W-1:0] RST_SER_OUT_EN   = 8'h00;
  localparam logic [PORT_W-1:0] RST_SER_OUT_LVL  = 8'hFF;
  localparam logic [PORT_W-1:0] RST_CHAN_EN      = 8'h00;
  localparam logic [PORT_W-1:0] RST_TMR_OUT_EN   = 8'h00;
  localparam logic [PORT_W-1:0] RST_TMR_OUT_LVL  = 8'h00;
  localparam logic [PORT_W-1:0] RST_CLK_OUT_SEL  = 8'h00;

  // ==========================================================
  // Field positions and pin wiring
  localparam int unsigned CLK_OUT_EN_BIT   = 0;
  localparam int unsigned REDIR_BUZ_BIT    = 0;
  localparam int unsigned BUZ_PIN_NORMAL   = 0;
  localparam int unsigned BUZ_PIN_REDIRECT = 4;
  // Pins that own a serial output, a non-serial output, an open-drain option
  localparam logic [PORT_W-1:0] HAS_SER_MASK = 8'h0F;
  localparam logic [PORT_W-1:0] HAS_NS_MASK  = 8'hFF;
  localparam logic [PORT_W-1:0] HAS_OD_MASK  = 8'hF0;

  // ==========================================================
  // Bus handshake phases
  typedef enum logic {BUS_WAIT, BUS_ANSWER} plao_bus_type;

endpackage : plao_pkg

/* File: src/plao_sync_if.sv */
// Carrier between the pin synchroniser and the port core
interface plao_sync_if;
  import plao_pkg::*;
  logic [PORT_W-1:0] pin_raw;
  logic [PORT_W-1:0] pin_level;
  modport core (output pin_raw, input pin_level);
  modport sync (input pin_raw, output pin_level);
endinterface : plao_sync_if

/* File: src/plao_pin_sync.sv */
// Three-stage pin input synchroniser with agreement filter
module plao_pin_sync
  import plao_pkg::*;
(
  // Clock and control
  input wire logic  clk,
  input wire logic  sys_rst,
  input wire logic  ce,
  // Pin levels
  plao_sync_if.sync sif
);

  logic [PORT_W-1:0] s1_r;
  logic [PORT_W-1:0] s2_r;
  logic [PORT_W-1:0] s3_r;
  logic [PORT_W-1:0] level_r;
  logic [PORT_W-1:0] agree;
  logic [PORT_W-1:0] level_nxt;

  // A bit changes only once the second and third stages agree
  assign agree     = ~(s2_r ^ s3_r);
  assign level_nxt = (agree & s3_r) | (~agree & level_r);
  assign sif.pin_level = level_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_r    <= '0;
      s2_r    <= '0;
      s3_r    <= '0;
      level_r <= '0;
    end else if (ce) begin
      s1_r    <= sif.pin_raw;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      level_r <= level_nxt;
    end
  end

endmodule // plao_pin_sync

/* File: verif/plao_port_asserts.sv */
// Concurrent checks on the ports of the port latch block
module plao_port_asserts
  import plao_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic              ce,
  // Register bus
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0]        avs_byteenable,
  input wire logic [DATA_W-1:0] avs_readdata,
  input wire logic              avs_waitrequest,
  // Alternates and pins
  input wire logic [PORT_W-1:0] serial_unit_out,
  input wire logic [PORT_W-1:0] timer_unit_out,
  input wire logic              clock_buzzer_output,
  input wire logic [PORT_W-1:0] pin_out,
  input wire logic [PORT_W-1:0] pin_oe,
  input wire logic [PORT_W-1:0] analog_select_ctrl
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Shadow registers, so outputs can be judged without the design's state
  wire logic wr_done  = avs_write & ~avs_waitrequest & ce & avs_byteenable[0];
  wire logic wr_latch = wr_done & (avs_address[7:2] == OFS_PORT_LATCH[7:2]);
  wire logic wr_mode  = wr_done & (avs_address[7:2] == OFS_PORT_MODE[7:2]);
  wire logic wr_anl   = wr_done & (avs_address[7:2] == OFS_ANALOG_SEL[7:2]);
  wire logic rd_port  = avs_read & ~avs_waitrequest & ce & (avs_address[7:2] == OFS_PORT_LATCH[7:2]);
  logic [PORT_W-1:0] latch_r;
  logic [PORT_W-1:0] mode_r;
  logic [PORT_W-1:0] anl_r;
  always_ff @(posedge clk) begin
    if (sys_rst && ce) begin
      latch_r <= RST_PORT_LATCH;
      mode_r  <= RST_PORT_MODE;
      anl_r   <= RST_ANALOG_SEL;
    end else begin
      if (wr_latch) latch_r <= avs_writedata[7:0];
      if (wr_mode) mode_r <= avs_writedata[7:0];
      if (wr_anl) anl_r <= avs_writedata[7:0];
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence taken_s;
    (avs_read || avs_write) && avs_waitrequest && ce;
  endsequence
  // No register store, then alternates unchanged for a cycle
  sequence quiet_s;
    !wr_done && ce ##1 ce && $stable(serial_unit_out) && $stable(timer_unit_out) && $stable(clock_buzzer_output);
  endsequence

  reset_clear_a: assert property ($past(sys_rst) && $past(ce) |-> pin_out == '0 && pin_oe == '0)
    else $error("pin state not cleared by reset");
  reset_analog_a: assert property ($past(sys_rst) && $past(ce) |-> analog_select_ctrl == 8'hFF)
    else $error("analog select not set by reset");
  bus_answer_a: assert property (taken_s |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus access not answered after one wait state");
  latch_hold_a: assert property (quiet_s |=> $stable(pin_out) && $stable(pin_oe))
    else $error("pin output moved without a write");
  mode_drive_a: assert property ((pin_oe & $past(mode_r)) == '0)
    else $error("input mode pin is driven");
  analog_drive_a: assert property ((pin_oe & $past(anl_r)) == '0)
    else $error("analog pin is driven");
  out_read_a: assert property (rd_port |-> ((avs_readdata[7:0] ^ latch_r) & ~mode_r & ~anl_r) == '0)
    else $error("output bit read differs from latch");
  analog_read_a: assert property (rd_port |-> (avs_readdata[7:0] & anl_r & mode_r) == '0 && avs_readdata[31:8] == '0)
    else $error("analog bit read not zero");
  latch_pass_a: assert property ((($past(latch_r) & ~pin_out) & ~HAS_SER_MASK) == '0)
    else $error("latch high not passed on pin without serial output");
endmodule // plao_port_asserts

bind plao_port plao_port_asserts u_asserts (.clk, .sys_rst, .ce, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .serial_unit_out, .timer_unit_out,
  .clock_buzzer_output, .pin_out, .pin_oe, .analog_select_ctrl);

/* File: verif/plao_pin_model.sv */
// Model of the board pins and of the peripherals behind the alternate outputs
module plao_pin_model
  import plao_pkg::*;
(
  // Levels from the port
  input  wire logic [PORT_W-1:0] pin_out,
  input  wire logic [PORT_W-1:0] pin_oe,
  // Commands from the bench
  input  wire logic [PORT_W-1:0] ext_level,
  input  wire logic [PORT_W-1:0] ser_level,
  input  wire logic [PORT_W-1:0] tmr_level,
  input  wire logic              buz_level,
  input  wire logic              alt_on,
  // Levels into the port
  output logic      [PORT_W-1:0] pin_in,
  output logic      [PORT_W-1:0] serial_unit_out,
  output logic      [PORT_W-1:0] timer_unit_out,
  output logic                   clock_buzzer_output
);
  timeunit 1ns;
  timeprecision 1ps;
  // A driven pin shows the port level, an undriven one what the board puts on it
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
  // Idle peripherals park high or low so they never mask the latch
  assign serial_unit_out     = alt_on ? ser_level : '1;
  assign timer_unit_out      = alt_on ? tmr_level : '0;
  assign clock_buzzer_output = alt_on & buz_level;
endmodule // plao_pin_model

/* File: verif/tb_plao_port.sv */
// Self-checking bench for the port latch block
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; $display("CHECK FAILED %s exp %h seen %h", n, e, g); end end
module tb_plao_port
  import plao_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ROFS [10] = '{OFS_PORT_MODE, OFS_ANALOG_SEL, OFS_OPEN_DRAIN, OFS_PIN_REDIRECT,
    OFS_SER_OUT_EN, OFS_SER_OUT_LVL, OFS_CHAN_EN, OFS_TMR_OUT_EN, OFS_TMR_OUT_LVL, OFS_CLK_OUT_SEL};
  localparam logic [7:0] RVAL [10] = '{RST_PORT_MODE, RST_ANALOG_SEL, RST_OPEN_DRAIN, RST_PIN_REDIRECT,
    RST_SER_OUT_EN, RST_SER_OUT_LVL, RST_CHAN_EN, RST_TMR_OUT_EN, RST_TMR_OUT_LVL, RST_CLK_OUT_SEL};
  logic              clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              ce = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [DATA_W-1:0] avs_writedata = '0;
  logic [3:0]        avs_byteenable = 4'hF;
  logic [PORT_W-1:0] ext_level = 8'h00;
  logic [PORT_W-1:0] ser_level = 8'hFF;
  logic [PORT_W-1:0] tmr_level = 8'h00;
  logic              buz_level = 1'b0;
  logic              alt_on = 1'b0;
  logic [7:0]        q;
  wire  [DATA_W-1:0] avs_readdata;
  wire               avs_waitrequest;
  wire  [PORT_W-1:0] pin_in, pin_out, pin_oe, analog_select_ctrl, serial_unit_out, timer_unit_out;
  wire               clock_buzzer_output;
  int                mismatches = 0;
  int                checks_done = 0;

  always #5 clk = ~clk;

  plao_port u_dut (.clk, .sys_rst, .ce, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .serial_unit_out, .timer_unit_out,
    .clock_buzzer_output, .pin_in, .pin_out, .pin_oe, .analog_select_ctrl);
  plao_pin_model u_model (.pin_out, .pin_oe, .ext_level, .ser_level, .tmr_level, .buz_level, .alt_on,
    .pin_in, .serial_unit_out, .timer_unit_out, .clock_buzzer_output);

  // ==========================================================
  // Bus and check tasks
  task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
    @(posedge clk);
    avs_address    <= a;
    avs_writedata  <= {24'h0, d};
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= ~wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus_xfer(1'b1, a, d, 4'h1);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string n);
    bus_xfer(1'b0, a, 8'h00, 4'h0);
    `CHK(n, e, q)
  endtask
  // Pin outputs follow one edge after the store, so look two edges on
  task automatic pin_chk(input logic [7:0] e_out, input logic [7:0] e_oe);
    repeat (2) @(posedge clk);
    `CHK("pin_out", e_out, pin_out)
    `CHK("pin_oe", e_oe, pin_oe)
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================================
  // Tests
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 10; i++) rd_chk(ROFS[i], RVAL[i], "reset value");
    rd_chk(8'h30, 8'h00, "unmapped");
    `CHK("analog", 8'hFF, analog_select_ctrl)
    $display("test reset values done");
    wr(OFS_ANALOG_SEL, 8'h00);
    wr(OFS_PORT_MODE, 8'h00);
    rd_chk(OFS_PORT_LATCH, 8'h00, "latch after reset");
    wr(OFS_PORT_LATCH, 8'hA5);
    pin_chk(8'hA5, 8'hFF);
    bus_xfer(1'b1, OFS_PORT_LATCH, 8'h11, 4'hE);
    rd_chk(OFS_PORT_LATCH, 8'hA5, "latch read");
    $display("test output mode done");
    ext_level <= 8'h96;
    wr(OFS_PORT_MODE, 8'hF0);
    wr(OFS_PORT_LATCH, 8'h3C);
    pin_chk(8'h3C, 8'h0F);
    repeat (8) @(posedge clk);
    rd_chk(OFS_PORT_LATCH, (8'h3C & 8'h0F) | (8'h96 & 8'hF0), "mixed read");
    bus_xfer(1'b0, OFS_PORT_LATCH, 8'h00, 4'h0);
    wr(OFS_PORT_LATCH, q ^ 8'hFF);
    wr(OFS_PORT_MODE, 8'h00);
    pin_chk(8'h63, 8'hFF);
    bus_xfer(1'b0, OFS_PORT_LATCH, 8'h00, 4'h0);
    wr(OFS_PORT_LATCH, q | 8'h80);
    rd_chk(OFS_PORT_LATCH, 8'hE3, "modify output");
    $display("test input mode done");
    alt_on <= 1'b1;
    ser_level <= 8'h05;
    tmr_level <= 8'hA0;
    buz_level <= 1'b1;
    wr(OFS_PORT_LATCH, 8'hFF);
    wr(OFS_SER_OUT_EN, 8'h0F);
    wr(OFS_CHAN_EN, 8'h0F);
    pin_chk(8'hF5, 8'hFF);
    wr(OFS_SER_OUT_EN, 8'h00);
    wr(OFS_PORT_LATCH, 8'h00);
    wr(OFS_TMR_OUT_EN, 8'hF0);
    pin_chk(8'hA0, 8'hFF);
    wr(OFS_TMR_OUT_EN, 8'h00);
    wr(OFS_TMR_OUT_LVL, 8'h0C);
    pin_chk(8'h0C, 8'hFF);
    wr(OFS_TMR_OUT_LVL, 8'h00);
    wr(OFS_CLK_OUT_SEL, 8'h01);
    pin_chk(8'h01, 8'hFF);
    wr(OFS_PIN_REDIRECT, 8'h01);
    pin_chk(8'h10, 8'hFF);
    wr(OFS_CLK_OUT_SEL, 8'h00);
    wr(OFS_SER_OUT_LVL, 8'hFE);
    wr(OFS_PORT_LATCH, 8'hF1);
    pin_chk(8'hF0, 8'hFF);
    alt_on <= 1'b0;
    $display("test alternates done");
    wr(OFS_OPEN_DRAIN, 8'hFF);
    wr(OFS_PORT_LATCH, 8'h5A);
    pin_chk(8'h5A, 8'hAF);
    wr(OFS_ANALOG_SEL, 8'h0F);
    pin_chk(8'h5A, 8'hA0);
    wr(OFS_PORT_MODE, 8'h0F);
    rd_chk(OFS_PORT_LATCH, 8'h50, "analog read");
    `CHK("analog", 8'h0F, analog_select_ctrl)
    $display("test open drain and analog done");
    ce <= 1'b0;
    fork
      wr(OFS_PORT_LATCH, 8'h00);
      begin
        repeat (6) @(posedge clk);
        `CHK("frozen pin_out", 8'h5A, pin_out)
        `CHK("frozen wait", 1'b1, avs_waitrequest)
        ce <= 1'b1;
      end
    join
    pin_chk(8'h00, 8'hF0);
    $display("test clock enable done");
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    pin_chk(8'h00, 8'h00);
    `CHK("analog", 8'hFF, analog_select_ctrl)
    wr(OFS_ANALOG_SEL, 8'h00);
    wr(OFS_PORT_MODE, 8'h00);
    rd_chk(OFS_PORT_LATCH, 8'h00, "latch after reset");
    $display("test second reset done");
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    complete_run();
  end
endmodule // tb_plao_port
